// *** hw/shq_framer.sv ***
// Purpose: QoS DSCP rewrite control and stacking header insert and check.
// Assumes: Byte streams come from logic on sys_clk, so no synchronisers.
// Notes:   The internal frame header is consumed here and never emitted.
module shq_framer
  import shq_pkg::*;
#(
  parameter logic [15:0] STK_ETYPE = 16'h0abc // Arbitrary value.
)
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic frm_valid,
  input wire shq_pkg::shq_int_qos_t frm_qos,
  input wire logic [5:0] frm_dscp,
  input wire logic [5:0] frm_remap_dscp,
  input wire logic frm_to_front,
  output logic dscp_valid,
  output logic [5:0] dscp_out,
  output logic dscp_changed,
  input wire logic stk_start,
  input wire shq_pkg::shq_stk_t stk_fields,
  input wire logic stk_ready,
  output logic stk_busy,
  output logic stk_valid,
  output logic [7:0] stk_byte,
  output logic stk_last,
  input wire logic misc_index_select,
  input wire logic rx_valid,
  input wire logic rx_sof,
  input wire logic [7:0] rx_byte,
  output logic rx_hdr_valid,
  output shq_pkg::shq_stk_t rx_fields,
  output logic rx_hdr_err
);

  // --------------------------------------------------------------------
  // DSCP rewrite decision.
  // --------------------------------------------------------------------
  logic dv_r, dv_nxt;
  logic [5:0] dscp_r, dscp_nxt;
  logic chg_r, chg_nxt;

  // Keep wins over update; CPU-bound frames are never rewritten.
  always_comb begin
    dv_nxt = frm_valid;
    dscp_nxt = dscp_r;
    chg_nxt = chg_r;
    if (frm_valid) begin
      if (!frm_to_front) begin
        dscp_nxt = frm_dscp;
      end else if (frm_qos.keep_dscp_flag) begin
        dscp_nxt = frm_dscp;
      end else if (frm_qos.dscp_update_flag) begin
        dscp_nxt = frm_qos.dscp;
      end else begin
        dscp_nxt = frm_remap_dscp;
      end
      chg_nxt = (dscp_nxt != frm_dscp);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dv_r <= 1'b0;
      dscp_r <= DSCP_RST;
      chg_r <= 1'b0;
    end else if (ce) begin
      dv_r <= dv_nxt;
      dscp_r <= dscp_nxt;
      chg_r <= chg_nxt;
    end
  end

  assign dscp_valid = dv_r;
  assign dscp_out = dscp_r;
  assign dscp_changed = chg_r;

  // --------------------------------------------------------------------
  // Stacking header insertion.
  // --------------------------------------------------------------------
  logic tx_go;

  assign tx_go = stk_start && !stk_busy;

  // The packer forces the top bit and leaves reserved bits zero.
  shq_hdr_tx u_tx (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ce(ce),
    .start(stk_start),
    .hdr(shq_pack(stk_fields)),
    .etype(STK_ETYPE),
    .out_ready(stk_ready),
    .busy(stk_busy),
    .out_valid(stk_valid),
    .out_byte(stk_byte),
    .out_last(stk_last)
  );

  // --------------------------------------------------------------------
  // Stacking header extraction and check.
  // --------------------------------------------------------------------
  logic [95:0] rsh_r, rsh_nxt;
  logic [3:0] rcnt_r, rcnt_nxt;
  logic ract_r, ract_nxt;
  logic hv_r, hv_nxt;
  logic herr_r, herr_nxt;
  shq_stk_t rf_r, rf_nxt;
  logic [95:0] rfull;

  assign rfull = {rsh_r[87:0], rx_byte};

  // Collects 12 bytes from a start marker, then checks and unpacks them.
  always_comb begin
    rsh_nxt = rsh_r;
    rcnt_nxt = rcnt_r;
    ract_nxt = ract_r;
    hv_nxt = 1'b0;
    herr_nxt = herr_r;
    rf_nxt = rf_r;
    if (rx_valid && (rx_sof || ract_r)) begin
      rsh_nxt = rfull;
      rcnt_nxt = rx_sof ? 4'h1 : rcnt_r + 4'h1;
      ract_nxt = 1'b1;
      if (!rx_sof && rcnt_r == LAST_IDX) begin
        ract_nxt = 1'b0;
        hv_nxt = 1'b1;
        herr_nxt = (rfull[95:80] != STK_ETYPE) || !rfull[TOP_BIT];
        // Fields are handed on as information only.
        rf_nxt = shq_unpack(rfull[79:0], misc_index_select);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rsh_r <= '0;
      rcnt_r <= CNT_RST;
      ract_r <= 1'b0;
      hv_r <= 1'b0;
      herr_r <= 1'b0;
      rf_r <= '0;
    end else if (ce) begin
      rsh_r <= rsh_nxt;
      rcnt_r <= rcnt_nxt;
      ract_r <= ract_nxt;
      hv_r <= hv_nxt;
      herr_r <= herr_nxt;
      rf_r <= rf_nxt;
    end
  end

  assign rx_hdr_valid = hv_r;
  assign rx_hdr_err = herr_r;
  assign rx_fields = rf_r;

  // --------------------------------------------------------------------
  // Checking helpers: position of the byte sent and the latched fields.
  // --------------------------------------------------------------------
  logic [3:0] aidx_r;
  shq_stk_t afld_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      aidx_r <= CNT_RST;
      afld_r <= '0;
    end else if (ce) begin
      if (tx_go) begin
        aidx_r <= CNT_RST;
        afld_r <= stk_fields;
      end else if (stk_valid && stk_ready) begin
        aidx_r <= aidx_r + 4'h1;
      end
    end
  end

  property p_keep;
    @(posedge sys_clk) disable iff (!nrst)
    ce && frm_valid && frm_to_front && frm_qos.keep_dscp_flag |=>
      dscp_out == $past(frm_dscp);
  endproperty
  a_keep: assert property (p_keep) else $error("DSCP remapped under keep");

  property p_upd;
    @(posedge sys_clk) disable iff (!nrst)
    ce && frm_valid && frm_to_front && !frm_qos.keep_dscp_flag &&
      frm_qos.dscp_update_flag |=> dscp_valid && dscp_out == $past(frm_qos.dscp);
  endproperty
  a_upd: assert property (p_upd) else $error("DSCP not updated");

  property p_cpu;
    @(posedge sys_clk) disable iff (!nrst)
    ce && frm_valid && !frm_to_front |=> !dscp_changed;
  endproperty
  a_cpu: assert property (p_cpu) else $error("CPU frame DSCP changed");

  property p_len;
    @(posedge sys_clk) disable iff (!nrst)
    stk_valid && stk_ready |-> stk_last == (aidx_r == LAST_IDX);
  endproperty
  a_len: assert property (p_len) else $error("Header not 12 bytes");

  property p_top;
    @(posedge sys_clk) disable iff (!nrst)
    stk_valid && aidx_r == 4'h2 |-> stk_byte[7];
  endproperty
  a_top: assert property (p_top) else $error("Top header bit not one");

  property p_misc;
    @(posedge sys_clk) disable iff (!nrst)
    stk_valid && aidx_r == 4'h3 |-> stk_byte == (afld_r.idx_sel ?
      afld_r.svc_idx[7:0] : {4'h0, afld_r.agg_code});
  endproperty
  a_misc: assert property (p_misc) else $error("Misc byte wrong");

  property p_qos;
    @(posedge sys_clk) disable iff (!nrst)
    stk_valid && aidx_r == 4'h4 |-> stk_byte ==
      {2'b00, afld_r.dp, afld_r.super_prio, afld_r.prio};
  endproperty
  a_qos: assert property (p_qos) else $error("QoS byte wrong");

  property p_etype;
    @(posedge sys_clk) disable iff (!nrst)
    stk_valid && aidx_r == 4'h0 |-> stk_byte == STK_ETYPE[15:8];
  endproperty
  a_etype: assert property (p_etype) else $error("EtherType not first");

  property p_rxchk;
    @(posedge sys_clk) disable iff (!nrst)
    ce && rx_valid && !rx_sof && ract_r && rcnt_r == LAST_IDX && !rsh_r[71]
      |=> rx_hdr_valid && rx_hdr_err;
  endproperty
  a_rxchk: assert property (p_rxchk) else $error("Bad top bit accepted");

endmodule

// *** hw/shq_hdr_tx.sv ***
// Purpose: Sends the 12 inserted bytes, EtherType first, then the payload.
// Assumes: Consumer on the same clock with a valid/ready handshake.
// Notes:   Starts requested while busy are ignored.
module shq_hdr_tx
  import shq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic start,
  input wire logic [79:0] hdr,
  input wire logic [15:0] etype,
  input wire logic out_ready,
  output logic busy,
  output logic out_valid,
  output logic [7:0] out_byte,
  output logic out_last
);

  typedef enum logic {ST_IDLE, ST_SEND} shq_tx_st_t;

  shq_tx_st_t st_r, st_nxt;
  logic [95:0] sh_r, sh_nxt;
  logic [3:0] idx_r, idx_nxt;

  // --------------------------------------------------------------------
  // Next state: load on start, shift one byte per accepted transfer.
  // --------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    idx_nxt = idx_r;
    unique case (st_r)
      ST_IDLE: begin
        if (start) begin
          sh_nxt = {etype, hdr};
          idx_nxt = CNT_RST;
          st_nxt = ST_SEND;
        end
      end
      ST_SEND: begin
        if (out_ready) begin
          sh_nxt = {sh_r[87:0], 8'h00};
          idx_nxt = idx_r + 4'h1;
          if (idx_r == LAST_IDX) begin
            st_nxt = ST_IDLE;
          end
        end
      end
    endcase
  end

  // Registers, frozen while the clock enable is low.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= ST_IDLE;
      sh_r <= '0;
      idx_r <= CNT_RST;
    end else if (ce) begin
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      idx_r <= idx_nxt;
    end
  end

  // Byte presented is always the top of the shift register.
  assign busy = (st_r == ST_SEND);
  assign out_valid = busy && ce;
  assign out_byte = sh_r[95:88];
  assign out_last = busy && (idx_r == LAST_IDX);

endmodule

// *** inc/shq_pkg.sv ***
// Purpose: Shared constants, types and helpers for the stacking header block.
// Assumes: One clock domain; the far end is logic on the same clock.
// Notes:   Bit positions are those of the 80-bit stacking payload or of the QoS part of the internal frame header.
package shq_pkg;

  // ----------------------------------------------------------------------
  // Sizes of the inserted header.
  // ----------------------------------------------------------------------
  localparam int STK_BYTES = 10;
  localparam int ETYPE_BYTES = 2;
  localparam int INS_BYTES = 12;
  localparam int STK_BITS = 80;
  localparam int INS_BITS = 96;

  // ----------------------------------------------------------------------
  // Field positions in the stacking payload.
  // ----------------------------------------------------------------------
  localparam int TOP_BIT = 79;
  localparam int COS_LO = 76;
  localparam int SVC_LO = 64;
  localparam int AGG_LO = 64;
  localparam int RSVM_LO = 68;
  localparam int RSV_LO = 62;
  localparam int DP_LO = 60;
  localparam int SUPER_BIT = 59;
  localparam int PRIO_LO = 56;

  // ----------------------------------------------------------------------
  // Field positions in the QoS part of the internal frame header.
  // ----------------------------------------------------------------------
  localparam int KEEP_BIT = 7;
  localparam int UPD_BIT = 6;

  // ----------------------------------------------------------------------
  // Reset values and the index of the last header byte.
  // ----------------------------------------------------------------------
  localparam logic [5:0] DSCP_RST = 6'h00;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [3:0] LAST_IDX = 4'hb;

  // Fields carried by the first part of the stacking header.
  typedef struct packed {
    logic idx_sel;
    logic [2:0] cos;
    logic [11:0] svc_idx;
    logic [3:0] agg_code;
    logic [1:0] dp;
    logic super_prio;
    logic [2:0] prio;
  } shq_stk_t;

  // QoS part of the internal frame header.
  typedef struct packed {
    logic keep_dscp_flag;
    logic dscp_update_flag;
    logic [5:0] dscp;
  } shq_int_qos_t;

  // Builds the 80-bit payload; lower fields are left zero.
  function automatic logic [79:0] shq_pack(input shq_stk_t f);
    logic [79:0] h;
    h = '0;
    h[TOP_BIT] = 1'b1;
    if (f.idx_sel) begin
      h[COS_LO+:3] = f.cos;
      h[SVC_LO+:12] = f.svc_idx;
    end else begin
      h[AGG_LO+:4] = f.agg_code;
    end
    h[DP_LO+:2] = f.dp;
    h[SUPER_BIT] = f.super_prio;
    h[PRIO_LO+:3] = f.prio;
    return h;
  endfunction

  // Extracts the fields; reserved misc bits are ignored.
  function automatic shq_stk_t shq_unpack(input logic [79:0] h,
                                          input logic sel);
    shq_stk_t f;
    f = '0;
    f.idx_sel = sel;
    if (sel) begin
      f.cos = h[COS_LO+:3];
      f.svc_idx = h[SVC_LO+:12];
    end else begin
      f.agg_code = h[AGG_LO+:4];
    end
    f.dp = h[DP_LO+:2];
    f.super_prio = h[SUPER_BIT];
    f.prio = h[PRIO_LO+:3];
    return f;
  endfunction

endpackage

// *** verif/shq_far_end.sv ***
// Purpose: Far end model that takes sent headers and sends received ones.
// Assumes: Same clock as the block; it moves bytes on rising edges.
// Notes:   Idle receive data shows the inverse of the last byte.
module shq_far_end
  import shq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic slow,
  input wire logic stk_valid,
  input wire logic [7:0] stk_byte,
  output logic stk_ready,
  output logic rx_valid,
  output logic rx_sof,
  output logic [7:0] rx_byte,
  output logic [95:0] cap,
  output logic [7:0] n_cap
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet lines at time zero.
  initial begin
    stk_ready = 1'b0;
    rx_valid = 1'b0;
    rx_sof = 1'b0;
    rx_byte = 8'h00;
    cap = '0;
    n_cap = 8'h00;
  end

  // Takes bytes as information only; slow mode stalls every other cycle.
  always @(posedge sys_clk) begin
    stk_ready <= slow ? ~stk_ready : 1'b1;
    if (stk_valid && stk_ready) begin
      cap <= {cap[87:0], stk_byte};
      n_cap <= n_cap + 8'h01;
    end
  end

  // Sends one inserted header, EtherType first, top byte first.
  task automatic send(input logic [95:0] h);
    for (int i = 0; i < 12; i++) begin
      @(posedge sys_clk);
      rx_valid <= 1'b1;
      rx_sof <= (i == 0);
      rx_byte <= h[95 - 8 * i -: 8];
    end
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_sof <= 1'b0;
    rx_byte <= ~rx_byte;
  endtask
endmodule

// *** verif/shq_framer_tb.sv ***
// Purpose: Self-checking bench for the DSCP and stacking header block.
// Assumes: One clock; the far end model shares it.
// Notes:   Expected headers are built here from the field layout.
module shq_framer_tb
  import shq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------
  localparam logic [15:0] ET = 16'h5a3c; // Arbitrary value.
  logic sys_clk = 1'b0, nrst = 1'b0, ce = 1'b1, slow = 1'b0;
  logic frm_valid = 1'b0, frm_to_front = 1'b0, stk_start = 1'b0;
  logic [5:0] frm_dscp = 6'h00, frm_remap_dscp = 6'h00;
  shq_int_qos_t frm_qos = '0;
  shq_stk_t stk_fields = '0;
  logic misc_index_select = 1'b0;
  logic dscp_valid, dscp_changed, stk_ready, stk_busy, stk_valid, stk_last;
  logic rx_valid, rx_sof, rx_hdr_valid, rx_hdr_err;
  logic [5:0] dscp_out;
  logic [7:0] stk_byte, rx_byte, n_cap;
  logic [95:0] cap;
  logic [7:0] last_at = 8'h00;
  shq_stk_t rx_fields, fa, fb, fc;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;

  shq_framer #(.STK_ETYPE(ET)) i_shq_framer (
    .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .frm_valid(frm_valid),
    .frm_qos(frm_qos), .frm_dscp(frm_dscp),
    .frm_remap_dscp(frm_remap_dscp), .frm_to_front(frm_to_front),
    .dscp_valid(dscp_valid), .dscp_out(dscp_out),
    .dscp_changed(dscp_changed), .stk_start(stk_start),
    .stk_fields(stk_fields), .stk_ready(stk_ready), .stk_busy(stk_busy),
    .stk_valid(stk_valid), .stk_byte(stk_byte), .stk_last(stk_last),
    .misc_index_select(misc_index_select), .rx_valid(rx_valid),
    .rx_sof(rx_sof), .rx_byte(rx_byte), .rx_hdr_valid(rx_hdr_valid),
    .rx_fields(rx_fields), .rx_hdr_err(rx_hdr_err));

  shq_far_end i_shq_far_end (
    .sys_clk(sys_clk), .slow(slow), .stk_valid(stk_valid),
    .stk_byte(stk_byte), .stk_ready(stk_ready), .rx_valid(rx_valid),
    .rx_sof(rx_sof), .rx_byte(rx_byte), .cap(cap), .n_cap(n_cap));

  // --------------------------------------------------------------------
  // Clock, timeout and reporting
  // --------------------------------------------------------------------
  // A 4 ns clock.
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  // Cuts a hang short well past the expected run length.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      print_verdict();
    end
  end

  // Notes how many bytes had gone when the last-byte flag was accepted.
  always @(posedge sys_clk) begin
    if (stk_valid && stk_ready && stk_last) begin
      last_at <= n_cap;
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [95:0] e, g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  // Builds a payload from fields; fields below bit 56 stay zero.
  function automatic logic [79:0] mk(input shq_stk_t f);
    logic [14:0] misc;
    misc = f.idx_sel ? {f.cos, f.svc_idx} : {11'h000, f.agg_code};
    return {1'b1, misc, 2'b00, f.dp, f.super_prio, f.prio, 56'h0};
  endfunction

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  // Walks every port kind and flag pair through one decision each.
  task automatic t_dscp();
    logic [5:0] e;
    for (int k = 0; k < 8; k++) begin
      @(posedge sys_clk);
      frm_valid <= 1'b1;
      frm_to_front <= k[2];
      frm_qos <= '{k[1], k[0], 6'h33};
      frm_dscp <= 6'h11;
      frm_remap_dscp <= 6'h22;
      e = (!k[2] || k[1]) ? 6'h11 : k[0] ? 6'h33 : 6'h22;
      @(posedge sys_clk);
      frm_valid <= 1'b0;
      #1;
      chk("dscp_valid", 1, dscp_valid);
      chk("dscp_out", e, dscp_out);
      chk("dscp_changed", e != 6'h11, dscp_changed);
    end
  endtask

  // Holds the clock enable low over a request, which must only be taken once the enable returns.
  task automatic t_ce();
    @(posedge sys_clk);
    ce <= 1'b0;
    frm_valid <= 1'b1;
    frm_to_front <= 1'b1;
    frm_qos <= '{1'b0, 1'b1, 6'h2a};
    frm_dscp <= 6'h11;
    @(posedge sys_clk);
    ce <= 1'b1;
    #1;
    chk("dscp_valid frozen", 0, dscp_valid);
    @(posedge sys_clk);
    frm_valid <= 1'b0;
    #1;
    chk("dscp_valid", 1, dscp_valid);
    chk("dscp_out", 6'h2a, dscp_out);
  endtask

  // Sends a header with start held over busy; only one header may go.
  task automatic t_tx(input shq_stk_t f, input logic s);
    logic [7:0] n0;
    n0 = n_cap;
    @(posedge sys_clk);
    slow <= s;
    misc_index_select <= f.idx_sel;
    stk_fields <= f;
    stk_start <= 1'b1;
    repeat (3) @(posedge sys_clk);
    stk_start <= 1'b0;
    for (int k = 0; k < 60 && stk_busy !== 1'b0; k++) @(posedge sys_clk) #1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("byte count", 12, n_cap - n0);
    chk("last byte", n0 + 8'd11, last_at);
    chk("sent header", {ET, mk(f)}, cap);
  endtask

  // Receives one header and judges the decoded fields and error flag.
  task automatic t_rx(input logic [15:0] et, input logic [79:0] h,
                      input shq_stk_t f, input logic err);
    @(posedge sys_clk);
    misc_index_select <= f.idx_sel;
    i_shq_far_end.send({et, h});
    #1;
    for (int k = 0; k < 4 && rx_hdr_valid !== 1'b1; k++) @(posedge sys_clk) #1;
    chk("rx_hdr_valid", 1, rx_hdr_valid);
    chk("rx_hdr_err", err, rx_hdr_err);
    if (!err) chk("rx_fields", f, rx_fields);
  endtask

  // Main sequence.
  initial begin
    fa = '{1'b1, 3'h5, 12'habc, 4'h0, 2'h2, 1'b1, 3'h6};
    fb = '{1'b0, 3'h0, 12'h000, 4'h9, 2'h1, 1'b0, 3'h3};
    fc = '{1'b0, 3'h7, 12'hfff, 4'h9, 2'h1, 1'b0, 3'h3};
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    t_dscp();
    t_ce();
    t_tx(fa, 1'b0);
    t_tx(fc, 1'b1);
    t_rx(ET, mk(fa), fa, 1'b0);
    t_rx(ET, mk(fb) | {1'b0, 11'h7ff, 68'h0}, fb, 1'b0);
    t_rx(ET, mk(fa) & {1'b0, {79{1'b1}}}, fa, 1'b1);
    t_rx(~ET, mk(fa), fa, 1'b1);
    print_verdict();
  end
endmodule
